// ### pkg/smc_pkg.sv
// Sleep-mode controller constants, field layouts and timing counts
//
// Behaviour
// - Sleep only when sleep_enable is one and sleep runs; field picks mode.
// - Mode 00 Idle stops core and flash clocks, others keep running.
// - Mode 01 stops peripheral, core and flash clocks; converter clock runs.
// - Mode 10 Power-down stops oscillator and every generated clock.
// - Interrupt wake stalls four cycles after start-up, then resumes.
// - Register file and SRAM stay unchanged through sleep and wake.
// - Reset while asleep wakes the core at the reset vector.
// - Enabled ADC starts a conversion on entry to Idle or noise mode.
// - Idle wakes on any enabled interrupt and every other wake source.
// - Noise mode wakes only on converter, EEPROM and every Power-down source.
// - Power-down wakes only on reset, watchdog, address, level, pin change.
// - In deeper modes external pins wake only when level-sensitive.
// - Power-down wake waits the start-up time chosen by clock fuses.
// - detector_off_in_sleep is bit 6 of mcu control, reset zero.
// - Disabled detector turns off on Power-down entry, back on at wake.
// - Detector-off wake waits the full reset time-out.
// - Fuse-enabled detector stays on in all modes unless software off in Power-down.
// - ADC stays enabled asleep; first conversion after re-enable extended.
// - Comparator off in Power-down; reference kept when comparator uses it.
// - comparator_off bit powers the comparator down.
// - Unlock write both bits, then within four cycles set with unlock zero.
// - Off bit active three cycles after set, self-clears three cycles later.
package smc_pkg;
    // ------------------------------------------------------------
    // Register fields
    // ------------------------------------------------------------
    localparam int SLEEP_EN_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int DET_OFF_BIT = 6;
    localparam int DET_UNLOCK_BIT = 5;
    localparam logic [7:0] SLEEP_CTRL_MASK = 8'h07;
    localparam logic [2:0] SLEEP_CTRL_RST = 3'h0;
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_NOISE = 2'h1;
    localparam logic [1:0] MODE_PDOWN = 2'h2;
    localparam logic [1:0] FUSE_SLOW_RISE = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    typedef logic [22:0] smc_cnt_t;
    typedef logic [2:0] smc_seq_t;
    localparam int CLK_KHZ = 125000;
    localparam int RST_TIMEOUT_MS = 64;
    localparam int RST_TIMEOUT_CK = 14;
    localparam int RST_TIMEOUT_CYC = RST_TIMEOUT_CK
        + RST_TIMEOUT_MS * CLK_KHZ;
    localparam smc_cnt_t STARTUP_CK = 23'h00_0006;
    localparam smc_cnt_t HALT_CK = 23'h00_0004;
    localparam smc_seq_t UNLOCK_CK = 3'h4;
    localparam smc_seq_t DET_DELAY_CK = 3'h3;
    localparam smc_seq_t DET_HOLD_CK = 3'h3;
    // ------------------------------------------------------------
    // Clock domains {osc, adc, io, flash, cpu}
    // ------------------------------------------------------------
    localparam int DOM_CPU = 0;
    localparam int DOM_FLASH = 1;
    localparam int DOM_IO = 2;
    localparam int DOM_ADC = 3;
    localparam int DOM_OSC = 4;
    localparam logic [4:0] DOM_ALL = 5'h1F;
    localparam logic [4:0] DOM_IDLE = 5'h1C;
    localparam logic [4:0] DOM_NOISE = 5'h18;
    localparam logic [4:0] DOM_PDOWN = 5'h00;
    typedef enum logic [1:0] {
        SMC_ACTIVE, SMC_ASLEEP, SMC_START, SMC_HALT
    } smc_state_t;
    function automatic logic [4:0] smc_dom_mask(input logic [1:0] mode);
        case (mode)
            MODE_IDLE: smc_dom_mask = DOM_IDLE;
            MODE_NOISE: smc_dom_mask = DOM_NOISE;
            MODE_PDOWN: smc_dom_mask = DOM_PDOWN;
            default: smc_dom_mask = DOM_ALL;
        endcase
    endfunction
endpackage

// ### pkg/smc_wake_if.sv
// Wake-source bundle between the controller and its qualifier
`timescale 1ns/10ps
interface smc_wake_if;
    logic [1:0] mode;
    logic irq_any;
    logic [1:0] ext_irq;
    logic [1:0] ext_level;
    logic pin_change;
    logic twi_match;
    logic eeprom_ready;
    logic adc_done;
    logic wdt_irq;
    logic any_reset;
    logic wake_irq;
    logic wake_rst;
    modport ctrl (
        output mode, irq_any, ext_irq, ext_level, pin_change, twi_match,
        output eeprom_ready, adc_done, wdt_irq, any_reset,
        input wake_irq, wake_rst
    );
    modport qual (
        input mode, irq_any, ext_irq, ext_level, pin_change, twi_match,
        input eeprom_ready, adc_done, wdt_irq, any_reset,
        output wake_irq, wake_rst
    );
endinterface

// ### hdl/smc_wake_qual.sv
// Wake-source qualification per sleep mode
`timescale 1ns/10ps
module smc_wake_qual (
    // Wake bundle
    smc_wake_if.qual w
);
    logic level_hit;
    logic deep_hit;
    logic noise_hit;
    logic idle_hit;
    // Edge-configured pins are blind without the peripheral clock
    assign level_hit = |(w.ext_irq & w.ext_level);
    assign deep_hit = level_hit | w.pin_change | w.twi_match
        | w.wdt_irq;
    assign noise_hit = deep_hit | w.adc_done | w.eeprom_ready;
    assign idle_hit = noise_hit | w.irq_any | (|w.ext_irq);
    assign w.wake_rst = w.any_reset;
    assign w.wake_irq = (w.mode == smc_pkg::MODE_IDLE) ? idle_hit
        : (w.mode == smc_pkg::MODE_NOISE) ? noise_hit : deep_hit;
endmodule

// ### hdl/smc_det_off_seq.sv
// Timed unlock sequence for the detector-off-in-sleep bit
`timescale 1ns/10ps
module smc_det_off_seq (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Control register write
    input wire logic i_wr,
    input wire logic i_off,
    input wire logic i_unlock,
    // State
    output logic o_unlock,
    output logic o_off,
    output logic o_active
);
    smc_pkg::smc_seq_t unl_q;
    smc_pkg::smc_seq_t unl_d;
    smc_pkg::smc_seq_t off_q;
    smc_pkg::smc_seq_t off_d;
    logic open_wr;
    logic arm_wr;
    // Rewriting the unlock inside its window does not extend it
    assign open_wr = i_wr & i_off & i_unlock & (unl_q == '0);
    assign arm_wr = i_wr & i_off & ~i_unlock & (unl_q != '0);
    always_comb begin
        unl_d = unl_q;
        off_d = off_q;
        if (open_wr) begin
            unl_d = smc_pkg::UNLOCK_CK;
        end else if (arm_wr) begin
            unl_d = '0;
        end else if (unl_q != '0) begin
            unl_d = unl_q - 3'h1;
        end
        if (arm_wr) begin
            off_d = smc_pkg::DET_DELAY_CK + smc_pkg::DET_HOLD_CK;
        end else if (off_q != '0) begin
            off_d = off_q - 3'h1;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            unl_q <= '0;
            off_q <= '0;
        end else begin
            unl_q <= unl_d;
            off_q <= off_d;
        end
    end
    assign o_unlock = (unl_q != '0);
    assign o_off = (off_q != '0);
    assign o_active = o_off & (off_q <= smc_pkg::DET_HOLD_CK);
endmodule

// ### hdl/smc_sleep_ctrl.sv
// Sleep-mode controller: mode entry, clock gating and wake sequencing
`timescale 1ns/10ps
module smc_sleep_ctrl #(
    // Reset time-out in cycles, shorten for simulation
    parameter int unsigned P_RST_TIMEOUT_CYC = smc_pkg::RST_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Core side
    input wire logic i_sleep_instr,
    input wire logic i_sleep_ctrl_wr,
    input wire logic [7:0] i_sleep_ctrl_wdata,
    input wire logic i_mcu_ctrl_wr,
    input wire logic [7:0] i_mcu_ctrl_wdata,
    output logic [7:0] o_sleep_ctrl_rdata,
    output logic [7:0] o_mcu_ctrl_rdata,
    output logic o_core_halt,
    output logic o_irq_resume,
    output logic o_reset_vector,
    output logic o_sleeping,
    // Configuration
    input wire logic [1:0] i_startup_clock_fuses,
    input wire logic i_brownout_fuse_en,
    input wire logic i_adc_enable,
    input wire logic i_adc_conv_begin,
    input wire logic i_comparator_off,
    input wire logic i_comparator_uses_ref,
    // Wake sources, already gated by their enables
    input wire logic i_irq_any,
    input wire logic i_ext_irq_zero,
    input wire logic i_ext_irq_one,
    input wire logic [1:0] i_ext_irq_level,
    input wire logic i_pin_change,
    input wire logic i_twi_match,
    input wire logic i_eeprom_ready,
    input wire logic i_adc_done,
    input wire logic i_wdt_irq,
    input wire logic i_ext_reset,
    input wire logic i_wdt_reset,
    input wire logic i_brownout_reset,
    // Clock domain enables
    output logic o_core_clk_en,
    output logic o_flash_clk_en,
    output logic o_periph_clk_en,
    output logic o_conv_clk_en,
    output logic o_osc_en,
    // Analog enables
    output logic o_brownout_en,
    output logic o_comparator_en,
    output logic o_vref_en,
    output logic o_adc_start,
    output logic o_adc_extended
);
    // ------------------------------------------------------------
    // Sleep control register
    // ------------------------------------------------------------
    logic [2:0] sctl_q;
    logic [2:0] sctl_d;
    logic sleep_en;
    logic [1:0] mode_sel;
    logic sleep_go;
    logic det_unlock;
    logic det_off;
    logic det_active;

    assign sctl_d = i_sleep_ctrl_wr
        ? i_sleep_ctrl_wdata[2:0] & smc_pkg::SLEEP_CTRL_MASK[2:0] : sctl_q;
    assign sleep_en = sctl_q[smc_pkg::SLEEP_EN_BIT];
    assign mode_sel = sctl_q[smc_pkg::MODE_LSB +: 2];
    assign o_sleep_ctrl_rdata = {5'h00, sctl_q};

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sctl_q <= smc_pkg::SLEEP_CTRL_RST;
        end else begin
            sctl_q <= sctl_d;
        end
    end

    always_comb begin
        o_mcu_ctrl_rdata = 8'h00;
        o_mcu_ctrl_rdata[smc_pkg::DET_OFF_BIT] = det_off;
        o_mcu_ctrl_rdata[smc_pkg::DET_UNLOCK_BIT] = det_unlock;
    end

    smc_det_off_seq u_det_seq (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr(i_mcu_ctrl_wr),
        .i_off(i_mcu_ctrl_wdata[smc_pkg::DET_OFF_BIT]),
        .i_unlock(i_mcu_ctrl_wdata[smc_pkg::DET_UNLOCK_BIT]),
        .o_unlock(det_unlock),
        .o_off(det_off),
        .o_active(det_active)
    );

    // ------------------------------------------------------------
    // Wake qualification
    // ------------------------------------------------------------
    smc_wake_if wk ();
    smc_pkg::smc_state_t st_q;
    smc_pkg::smc_state_t st_d;
    logic [1:0] smode_q;
    logic [1:0] smode_d;

    assign wk.mode = smode_q;
    assign wk.irq_any = i_irq_any;
    assign wk.ext_irq = {i_ext_irq_one, i_ext_irq_zero};
    assign wk.ext_level = i_ext_irq_level;
    assign wk.pin_change = i_pin_change;
    assign wk.twi_match = i_twi_match;
    assign wk.eeprom_ready = i_eeprom_ready;
    assign wk.adc_done = i_adc_done;
    assign wk.wdt_irq = i_wdt_irq;
    assign wk.any_reset = i_ext_reset | i_wdt_reset | i_brownout_reset;

    smc_wake_qual u_qual (
        .w(wk.qual)
    );

    // ------------------------------------------------------------
    // Sleep sequencer
    // ------------------------------------------------------------
    // Reserved mode 11 is treated like a cleared enable
    assign sleep_go = i_sleep_instr & sleep_en
        & (mode_sel != 2'h3) & (st_q == smc_pkg::SMC_ACTIVE);

    smc_pkg::smc_cnt_t cnt_q;
    smc_pkg::smc_cnt_t cnt_d;
    smc_pkg::smc_cnt_t rst_cnt;
    smc_pkg::smc_cnt_t pd_cnt;
    logic rst_pend_q;
    logic rst_pend_d;
    logic doff_q;
    logic doff_d;
    logic resume_d;
    logic rvec_d;
    logic cnt_last;

    assign rst_cnt = smc_pkg::smc_cnt_t'(P_RST_TIMEOUT_CYC);
    // Slow start-up fuses and a detector-off sleep share the long wait
    assign pd_cnt = (doff_q
        || i_startup_clock_fuses == smc_pkg::FUSE_SLOW_RISE)
        ? rst_cnt : smc_pkg::STARTUP_CK;
    assign cnt_last = (cnt_q <= 23'h00_0001);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        smode_d = smode_q;
        rst_pend_d = rst_pend_q;
        doff_d = doff_q;
        resume_d = 1'b0;
        rvec_d = 1'b0;
        unique case (st_q)
            smc_pkg::SMC_ACTIVE: begin
                // Without the enable the instruction falls through
                if (sleep_go) begin
                    st_d = smc_pkg::SMC_ASLEEP;
                    smode_d = mode_sel;
                    doff_d = det_active & i_brownout_fuse_en
                        & (mode_sel == smc_pkg::MODE_PDOWN);
                end
            end
            smc_pkg::SMC_ASLEEP: begin
                if (wk.wake_rst) begin
                    st_d = smc_pkg::SMC_START;
                    cnt_d = rst_cnt;
                    rst_pend_d = 1'b1;
                end else if (wk.wake_irq) begin
                    if (smode_q == smc_pkg::MODE_PDOWN) begin
                        st_d = smc_pkg::SMC_START;
                        cnt_d = pd_cnt;
                    end else begin
                        st_d = smc_pkg::SMC_HALT;
                        cnt_d = smc_pkg::HALT_CK;
                    end
                end
            end
            smc_pkg::SMC_START: begin
                if (!cnt_last) begin
                    cnt_d = cnt_q - 23'h00_0001;
                end else if (rst_pend_q) begin
                    st_d = smc_pkg::SMC_ACTIVE;
                    rst_pend_d = 1'b0;
                    doff_d = 1'b0;
                    rvec_d = 1'b1;
                end else begin
                    st_d = smc_pkg::SMC_HALT;
                    cnt_d = smc_pkg::HALT_CK;
                end
            end
            smc_pkg::SMC_HALT: begin
                if (!cnt_last) begin
                    cnt_d = cnt_q - 23'h00_0001;
                end else begin
                    st_d = smc_pkg::SMC_ACTIVE;
                    doff_d = 1'b0;
                    resume_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_q <= smc_pkg::SMC_ACTIVE;
            cnt_q <= '0;
            smode_q <= smc_pkg::MODE_IDLE;
            rst_pend_q <= 1'b0;
            doff_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            smode_q <= smode_d;
            rst_pend_q <= rst_pend_d;
            doff_q <= doff_d;
        end
    end

    // ------------------------------------------------------------
    // Clock and analog enables
    // ------------------------------------------------------------
    // Outputs follow the next state so they line up with st_q
    logic [4:0] dom_d;
    logic [4:0] dom_q;
    logic asleep_d;
    logic pd_d;
    logic bod_d;
    logic cmp_d;
    logic vref_d;
    logic halt_q;
    logic resume_q;
    logic rvec_q;
    logic bod_q;
    logic cmp_q;
    logic vref_q;
    logic adc_go_q;

    assign asleep_d = (st_d == smc_pkg::SMC_ASLEEP);
    assign pd_d = (st_d == smc_pkg::SMC_ASLEEP
        || st_d == smc_pkg::SMC_START)
        && smode_d == smc_pkg::MODE_PDOWN;
    // Oscillator must run while the start-up count elapses
    assign dom_d = (st_d == smc_pkg::SMC_ACTIVE
        || st_d == smc_pkg::SMC_HALT) ? smc_pkg::DOM_ALL
        : asleep_d ? smc_pkg::smc_dom_mask(smode_d)
        : (smc_pkg::smc_dom_mask(smode_d)
        | (5'h01 << smc_pkg::DOM_OSC));
    assign bod_d = i_brownout_fuse_en
        & ~(asleep_d & doff_d);
    assign cmp_d = ~i_comparator_off & ~pd_d;
    assign vref_d = (i_comparator_uses_ref & ~i_comparator_off)
        | bod_d | i_adc_enable;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            dom_q <= smc_pkg::DOM_ALL;
            halt_q <= 1'b0;
            resume_q <= 1'b0;
            rvec_q <= 1'b0;
            bod_q <= 1'b0;
            cmp_q <= 1'b0;
            vref_q <= 1'b0;
            adc_go_q <= 1'b0;
        end else begin
            dom_q <= dom_d;
            // Core held so register file and SRAM stay intact
            halt_q <= (st_d != smc_pkg::SMC_ACTIVE);
            resume_q <= resume_d;
            rvec_q <= rvec_d;
            bod_q <= bod_d;
            cmp_q <= cmp_d;
            vref_q <= vref_d;
            adc_go_q <= sleep_go & i_adc_enable
                & (mode_sel != smc_pkg::MODE_PDOWN);
        end
    end

    assign o_core_clk_en = dom_q[smc_pkg::DOM_CPU];
    assign o_flash_clk_en = dom_q[smc_pkg::DOM_FLASH];
    assign o_periph_clk_en = dom_q[smc_pkg::DOM_IO];
    assign o_conv_clk_en = dom_q[smc_pkg::DOM_ADC];
    assign o_osc_en = dom_q[smc_pkg::DOM_OSC];
    assign o_core_halt = halt_q;
    assign o_irq_resume = resume_q;
    assign o_reset_vector = rvec_q;
    assign o_sleeping = (st_q == smc_pkg::SMC_ASLEEP);
    assign o_brownout_en = bod_q;
    assign o_comparator_en = cmp_q;
    assign o_vref_en = vref_q;
    assign o_adc_start = adc_go_q;

    // ------------------------------------------------------------
    // Extended conversion tracking
    // ------------------------------------------------------------
    // The converter keeps its enable through sleep; only a real
    // off-then-on cycle or a reset forces the long first conversion
    logic adc_en_q;
    logic ext_q;
    logic ext_set;
    logic ext_clr;

    assign ext_set = adc_en_q & ~i_adc_enable;
    assign ext_clr = i_adc_conv_begin | adc_go_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            adc_en_q <= 1'b0;
            ext_q <= 1'b1;
        end else begin
            adc_en_q <= i_adc_enable;
            ext_q <= ext_set | (ext_q & ~ext_clr);
        end
    end

    assign o_adc_extended = ext_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    property p_no_enable_no_sleep;
        i_sleep_instr && !sleep_en |=> !o_sleeping && !halt_q;
    endproperty
    a_no_enable_no_sleep: assert property (p_no_enable_no_sleep)
        else $error("sleep taken with enable clear");

    property p_idle_domains;
        o_sleeping && smode_q == smc_pkg::MODE_IDLE |->
            !o_core_clk_en && !o_flash_clk_en && o_periph_clk_en
            && o_conv_clk_en && o_osc_en;
    endproperty
    a_idle_domains: assert property (p_idle_domains)
        else $error("idle clock domains wrong");

    property p_noise_domains;
        o_sleeping && smode_q == smc_pkg::MODE_NOISE |->
            !o_core_clk_en && !o_periph_clk_en && o_conv_clk_en
            && o_osc_en;
    endproperty
    a_noise_domains: assert property (p_noise_domains)
        else $error("noise mode clock domains wrong");

    property p_pdown_domains;
        o_sleeping && smode_q == smc_pkg::MODE_PDOWN |->
            dom_q == smc_pkg::DOM_PDOWN && !o_comparator_en;
    endproperty
    a_pdown_domains: assert property (p_pdown_domains)
        else $error("power-down left a clock running");

    property p_halt_four;
        $rose(st_q == smc_pkg::SMC_HALT) |->
            (st_q == smc_pkg::SMC_HALT && o_core_halt) [*4]
            ##1 o_irq_resume && !o_core_halt;
    endproperty
    a_halt_four: assert property (p_halt_four)
        else $error("wake stall not four cycles");

    property p_reset_wake;
        o_sleeping && wk.wake_rst |=> st_q == smc_pkg::SMC_START
            && rst_pend_q && cnt_q == rst_cnt;
    endproperty
    a_reset_wake: assert property (p_reset_wake)
        else $error("reset wake not sequenced");

    property p_adc_start;
        sleep_go && i_adc_enable
            && mode_sel != smc_pkg::MODE_PDOWN |=> o_adc_start;
    endproperty
    a_adc_start: assert property (p_adc_start)
        else $error("conversion not started on entry");

    property p_pdown_start;
        o_sleeping && smode_q == smc_pkg::MODE_PDOWN
            && wk.wake_irq && !wk.wake_rst |=>
            st_q == smc_pkg::SMC_START && cnt_q == $past(pd_cnt)
            && o_osc_en;
    endproperty
    a_pdown_start: assert property (p_pdown_start)
        else $error("power-down wake skipped start-up");

    property p_noise_blind;
        o_sleeping && smode_q == smc_pkg::MODE_NOISE && !wk.wake_rst
            && !i_adc_done && !i_twi_match && !i_eeprom_ready
            && !i_wdt_irq && !i_pin_change
            && !(|(wk.ext_irq & i_ext_irq_level)) |=> o_sleeping;
    endproperty
    a_noise_blind: assert property (p_noise_blind)
        else $error("noise mode woke on a masked source");

    property p_det_off;
        o_sleeping && doff_q |-> !o_brownout_en;
    endproperty
    a_det_off: assert property (p_det_off)
        else $error("detector on during disabled sleep");

    property p_det_long;
        o_sleeping && doff_q && wk.wake_irq && !wk.wake_rst |=>
            cnt_q == rst_cnt ##1 o_brownout_en == i_brownout_fuse_en;
    endproperty
    a_det_long: assert property (p_det_long)
        else $error("detector-off wake too short");

    c_idle_wake: cover property (o_sleeping
        && smode_q == smc_pkg::MODE_IDLE ##1 o_core_halt [*4]
        ##1 o_irq_resume);
    c_pdown_wake: cover property (o_sleeping
        && smode_q == smc_pkg::MODE_PDOWN ##[1:40] o_irq_resume);
    c_reset_wake: cover property (o_sleeping ##[1:40] o_reset_vector);
    c_det_off_sleep: cover property (doff_q && o_sleeping);
endmodule

// ### tb/smc_wake_src.sv
// Far-side wake source holding a level request until it is taken
`timescale 1ns/10ps
module smc_wake_src (
    // Clock and control
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic i_ack,
    // Level request
    output logic o_req
);
    initial o_req = 1'b0;
    // Level kept until the core takes the interrupt
    always @(posedge i_clk_sys) begin
        if (i_go) begin
            o_req <= 1'b1;
        end else if (i_ack) begin
            o_req <= 1'b0;
        end
    end
endmodule

// ### tb/smc_sleep_ctrl_bench.sv
// Self-checking bench for the sleep-mode controller
`timescale 1ns/10ps
module smc_sleep_ctrl_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic instr = 1'b0, swr = 1'b0, mwr = 1'b0, adc = 1'b1, go = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [6:0] wk = 7'h00;
    logic [2:0] rs = 3'h0;
    logic [1:0] lvl = 2'h0, fz = 2'h0;
    logic ext0, rsm, rvec, slpg, brownout_detector, ast, hlt, cen, ext;
    logic [4:0] dom;
    logic [7:0] srd, mrd;
    int failures = 0;
    int checks_done = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    smc_sleep_ctrl #(.P_RST_TIMEOUT_CYC(20)) i_smc_sleep_ctrl (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sleep_instr(instr),
        .i_sleep_ctrl_wr(swr), .i_sleep_ctrl_wdata(wd),
        .i_mcu_ctrl_wr(mwr), .i_mcu_ctrl_wdata(wd),
        .o_sleep_ctrl_rdata(srd), .o_mcu_ctrl_rdata(mrd),
        .o_core_halt(hlt), .o_irq_resume(rsm), .o_reset_vector(rvec),
        .o_sleeping(slpg), .i_startup_clock_fuses(fz),
        .i_brownout_fuse_en(1'b1), .i_adc_enable(adc),
        .i_adc_conv_begin(1'b0), .i_comparator_off(1'b0),
        .i_comparator_uses_ref(1'b0), .i_irq_any(wk[0]),
        .i_ext_irq_zero(ext0), .i_ext_irq_one(wk[1]),
        .i_ext_irq_level(lvl), .i_pin_change(wk[2]), .i_twi_match(wk[3]),
        .i_eeprom_ready(wk[4]), .i_adc_done(wk[5]), .i_wdt_irq(wk[6]),
        .i_ext_reset(rs[0]), .i_wdt_reset(rs[1]),
        .i_brownout_reset(rs[2]), .o_core_clk_en(dom[0]),
        .o_flash_clk_en(dom[1]), .o_periph_clk_en(dom[2]),
        .o_conv_clk_en(dom[3]), .o_osc_en(dom[4]), .o_brownout_en(brownout_detector),
        .o_comparator_en(cen), .o_vref_en(), .o_adc_start(ast),
        .o_adc_extended(ext));
    smc_wake_src i_smc_wake_src (.i_clk_sys(i_clk_sys), .i_go(go),
        .i_ack(rsm), .o_req(ext0));
    task automatic step();
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic m, input logic [7:0] d);
        wd = d;
        swr = !m;
        mwr = m;
        step();
        swr = 1'b0;
        mwr = 1'b0;
    endtask
    task automatic slp(input logic [4:0] d, input logic a);
        instr = 1'b1;
        step();
        instr = 1'b0;
        cmp({1'b0, hlt, ast, dom}, {1'b0, d != 5'h1F, a, d});
    endtask
    // Cycles from raising a source to the core pulse
    task automatic wt(input int n, input logic rv);
        int k;
        k = 0;
        do begin
            step();
            k++;
        end while ((rv ? rvec : rsm) !== 1'b1 && k < 100);
        cmp(k[7:0], n[7:0]);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) step();
        i_rst_n = 1'b1;
        step();
        cmp(mrd, 8'h00);
        wr(0, 8'hFC);
        cmp(srd, 8'h04);
        slp(5'h1F, 1'b0);
        wr(0, 8'h07);
        slp(5'h1F, 1'b0);
        for (int i = 0; i < 7; i++) begin
            wr(0, 8'h01);
            slp(5'h1C, 1'b1);
            wk = 7'h01 << i;
            wt(5, 1'b0);
            wk = 7'h00;
        end
        cmp({7'h0, ext}, 8'h00);
        adc = 1'b0;
        wr(0, 8'h03);
        slp(5'h18, 1'b0);
        wk = 7'h01;
        repeat (3) step();
        cmp({6'h0, ext, slpg}, 8'h03);
        wk = 7'h20;
        wt(5, 1'b0);
        wk = 7'h00;
        adc = 1'b1;
        wr(0, 8'h05);
        slp(5'h00, 1'b0);
        cmp({6'h0, cen, brownout_detector}, 8'h01);
        go = 1'b1;
        step();
        go = 1'b0;
        repeat (2) step();
        cmp({7'h0, slpg}, 8'h01);
        lvl = 2'h1;
        wt(11, 1'b0);
        lvl = 2'h0;
        fz = 2'h2;
        wr(0, 8'h05);
        slp(5'h00, 1'b0);
        wk = 7'h08;
        wt(25, 1'b0);
        wk = 7'h00;
        fz = 2'h0;
        wr(0, 8'h05);
        wr(1, 8'h60);
        wr(1, 8'h40);
        cmp(mrd, 8'h40);
        repeat (3) step();
        slp(5'h00, 1'b0);
        cmp({7'h0, brownout_detector}, 8'h00);
        wk = 7'h40;
        wt(25, 1'b0);
        wk = 7'h00;
        cmp({7'h0, brownout_detector}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(0, 8'h01);
            slp(5'h1C, 1'b1);
            rs = 3'h1 << i;
            wt(21, 1'b1);
            rs = 3'h0;
        end
        tally_and_finish();
    end
    // Hang guard, far beyond the roughly two hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge i_clk_sys);
        failures++;
        tally_and_finish();
    end
endmodule
